// [logic/lsc_map.svh]
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// register addresses
`define LSC_ADDR_ANALOG_CONTROL    8'h0f
`define LSC_ADDR_PART_IDENTITY     8'h12
`define LSC_ADDR_DEVICE_STATUS     8'h13
`define LSC_ADDR_LIGHT_CH0_LOW     8'h14
`define LSC_ADDR_LIGHT_CH0_HIGH    8'h15
`define LSC_ADDR_LIGHT_CH1_LOW     8'h16
`define LSC_ADDR_LIGHT_CH1_HIGH    8'h17

// analog control field positions
`define LSC_CTRL_LED_MSB           7
`define LSC_CTRL_LED_LSB           6
`define LSC_CTRL_DIODE_MSB         5
`define LSC_CTRL_DIODE_LSB         4
`define LSC_CTRL_NGAIN_MSB         3
`define LSC_CTRL_NGAIN_LSB         2
`define LSC_CTRL_LGAIN_MSB         1
`define LSC_CTRL_LGAIN_LSB         0
`define LSC_CTRL_RESET             8'h00

// status bit positions
`define LSC_STAT_NEAR_SAT          6
`define LSC_STAT_NEAR_IRQ          5
`define LSC_STAT_LIGHT_IRQ         4
`define LSC_STAT_NEAR_VALID        1
`define LSC_STAT_LIGHT_VALID       0
`define LSC_STAT_RSVD_TOP          7
`define LSC_STAT_RSVD_MSB          3
`define LSC_STAT_RSVD_LSB          2

// the only legal diode code: proximity on the channel 1 diode
`define LSC_DIODE_CH1              2'h2

// led current in tenths of a milliamp, full and reduced by nine
`define LSC_LED_FULL_0             11'h3e8
`define LSC_LED_FULL_1             11'h1f4
`define LSC_LED_FULL_2             11'h0fa
`define LSC_LED_FULL_3             11'h07d
`define LSC_LED_LOW_0              11'h06f
`define LSC_LED_LOW_1              11'h038
`define LSC_LED_LOW_2              11'h01c
`define LSC_LED_LOW_3              11'h00e

// result byte halves and reset values
`define LSC_RESULT_HI_MSB          15
`define LSC_RESULT_HI_LSB          8
`define LSC_RESULT_LO_MSB          7
`define LSC_RESULT_LO_LSB          0
`define LSC_RESULT_RESET           16'h0000
`define LSC_BYTE_RESET             8'h00

`define LSC_READ_UNMAPPED          8'h00

`endif

// [logic/lsc_pkg.sv]
package lsc_pkg;

   typedef struct packed {
      logic [1:0] ledCurrentSelect;
      logic [1:0] senseDiodeSelect;
      logic [1:0] nearGainSelect;
      logic [1:0] lightGainSelect;
   } lsc_analog_control_s;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } lsc_reg_req_s;

   typedef struct packed {
      logic        done;
      logic [15:0] ch0;
      logic [15:0] ch1;
   } lsc_light_result_s;

endpackage

// [logic/lsc_regs.sv]
// Functional notes
// - Analog control at 0x0F holds led current, sense diode, near gain and light gain, two bits each.
// - Part identity at 0x12 is read-only and returns a fixed part code.
// - Device status at 0x13 is read-only and its bits 7, 3 and 2 read as zero.
// - Status bit 6 shows that the proximity measurement is saturated.
// - Status bit 0 is set once both light channels have finished an integration.
// - Each light channel result is 16 bits split into low and high bytes at consecutive addresses.
// - Channel 0 low byte sits at 0x14 and high byte at 0x15.
// - Channel 1 low byte sits at 0x16 and high byte at 0x17.
// - Reading a channel's low byte copies its upper eight result bits into a shadow latch.
// - The high-byte read returns the shadow, even if new results arrived since the low-byte read.
// - With led current reduce set, the selected led current is divided by nine.
// - Light interrupt decisions use only channel 0 results.
`timescale 1ns/100ps
`include "lsc_map.svh"

module lsc_regs #(
   parameter logic [7:0] PART_CODE = 8'h5a  // arbitrary value
) (
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   input  wire lsc_pkg::lsc_reg_req_s       regReq,
   output logic [7:0]                       regRdata,
   output logic                             regRvalid,
   input  wire lsc_pkg::lsc_light_result_s  lightResult,
   input  wire logic                        lightValidClear,
   input  wire logic [15:0]                 lightLowThresh,
   input  wire logic [15:0]                 lightHighThresh,
   input  wire logic                        lightIrqClear,
   input  wire logic                        nearDone,
   input  wire logic                        nearValidClear,
   input  wire logic                        nearSaturated,
   input  wire logic                        nearIrqActive,
   input  wire logic                        ledCurrentReduce,
   output lsc_pkg::lsc_analog_control_s     analogControl,
   output logic [10:0]                      ledCurrentTenthsMa,
   output logic                             diodeCodeLegal,
   output logic                             lightIrqFlag
);

   function automatic logic [10:0] ledCurrent(input logic [1:0] sel, input logic reduce);
      logic [10:0] val;
      val = 11'h000;
      unique case (sel)
         2'h0: val = reduce ? `LSC_LED_LOW_0 : `LSC_LED_FULL_0;
         2'h1: val = reduce ? `LSC_LED_LOW_1 : `LSC_LED_FULL_1;
         2'h2: val = reduce ? `LSC_LED_LOW_2 : `LSC_LED_FULL_2;
         2'h3: val = reduce ? `LSC_LED_LOW_3 : `LSC_LED_FULL_3;
      endcase
      return val;
   endfunction

   // flags that hardware sets and the far side clears: a set in the clearing cycle wins
   function automatic logic stickyNext(input logic set, input logic held, input logic clear);
      return set || (held && !clear);
   endfunction

   function automatic logic [7:0] upperByte(input logic [15:0] word);
      return word[`LSC_RESULT_HI_MSB:`LSC_RESULT_HI_LSB];
   endfunction

   function automatic logic [7:0] lowerByte(input logic [15:0] word);
      return word[`LSC_RESULT_LO_MSB:`LSC_RESULT_LO_LSB];
   endfunction

   // the control fields are cut out by the map, so the map must fill the carrier exactly
   if ($bits(lsc_pkg::lsc_analog_control_s) != `LSC_CTRL_LED_MSB + 1 ||
       `LSC_CTRL_LGAIN_LSB != 0) begin : g_ctrl_map_check
      $error("analog control map does not match its carrier");
   end

   logic [7:0]  controlFf;
   logic [15:0] ch0ResultFf;
   logic [15:0] ch1ResultFf;
   logic [7:0]  ch0ShadowFf;
   logic [7:0]  ch1ShadowFf;
   logic        lightValidFf;
   logic        nearValidFf;
   logic        lightIrqFf;
   logic        nearSatFf;
   logic        nearIrqFf;
   logic [7:0]  rdataFf;
   logic        rvalidFf;

   // address decode
   wire hitControl = regReq.addr == `LSC_ADDR_ANALOG_CONTROL;
   wire hitIdent   = regReq.addr == `LSC_ADDR_PART_IDENTITY;
   wire hitStatus  = regReq.addr == `LSC_ADDR_DEVICE_STATUS;
   wire hitCh0Low  = regReq.addr == `LSC_ADDR_LIGHT_CH0_LOW;
   wire hitCh0High = regReq.addr == `LSC_ADDR_LIGHT_CH0_HIGH;
   wire hitCh1Low  = regReq.addr == `LSC_ADDR_LIGHT_CH1_LOW;
   wire hitCh1High = regReq.addr == `LSC_ADDR_LIGHT_CH1_HIGH;

   wire writeControl = regReq.write && hitControl;
   wire readCh0Low   = regReq.read && hitCh0Low;
   wire readCh1Low   = regReq.read && hitCh1Low;

   // channel 0 alone drives the light threshold compare
   wire ch0BelowWindow  = lightResult.ch0 < lightLowThresh;
   wire ch0AboveWindow  = lightResult.ch0 > lightHighThresh;
   wire lightOutOfRange = lightResult.done && (ch0BelowWindow || ch0AboveWindow);

   wire [7:0] statusWord;
   assign statusWord[`LSC_STAT_RSVD_TOP]   = 1'b0;
   assign statusWord[`LSC_STAT_NEAR_SAT]   = nearSatFf;
   assign statusWord[`LSC_STAT_NEAR_IRQ]   = nearIrqFf;
   assign statusWord[`LSC_STAT_LIGHT_IRQ]  = lightIrqFf;
   assign statusWord[`LSC_STAT_RSVD_MSB:`LSC_STAT_RSVD_LSB] = 2'h0;
   assign statusWord[`LSC_STAT_NEAR_VALID] = nearValidFf;
   assign statusWord[`LSC_STAT_LIGHT_VALID] = lightValidFf;

   // low byte and shadow taken from the same stored result in the same cycle
   wire [7:0] readMux =
      hitControl ? controlFf :
      hitIdent   ? PART_CODE :
      hitStatus  ? statusWord :
      hitCh0Low  ? lowerByte(ch0ResultFf) :
      hitCh0High ? ch0ShadowFf :
      hitCh1Low  ? lowerByte(ch1ResultFf) :
      hitCh1High ? ch1ShadowFf :
      `LSC_READ_UNMAPPED;

   // read data holds between reads, so a slow sampler still sees it
   wire [7:0] nxt_rdata = regReq.read ? readMux : rdataFf;

   // set wins over clear on both valid flags and the light irq flag
   wire nxt_lightValid = stickyNext(lightResult.done, lightValidFf, lightValidClear);
   wire nxt_nearValid  = stickyNext(nearDone, nearValidFf, nearValidClear);
   wire nxt_lightIrq   = stickyNext(lightOutOfRange, lightIrqFf, lightIrqClear);

   // only the control register takes writes; every other address drops them
   always_ff @(posedge core_clk) begin
      if (reset) begin
         controlFf <= `LSC_CTRL_RESET;
      end else if (writeControl) begin
         controlFf <= regReq.wdata;
      end
   end

   // both channels land together, so valid never shows a half update
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ch0ResultFf <= `LSC_RESULT_RESET;
         ch1ResultFf <= `LSC_RESULT_RESET;
      end else if (lightResult.done) begin
         ch0ResultFf <= lightResult.ch0;
         ch1ResultFf <= lightResult.ch1;
      end
   end

   // shadow only moves on a low-byte read, not on new results
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ch0ShadowFf <= `LSC_BYTE_RESET;
         ch1ShadowFf <= `LSC_BYTE_RESET;
      end else begin
         if (readCh0Low) begin
            ch0ShadowFf <= upperByte(ch0ResultFf);
         end
         if (readCh1Low) begin
            ch1ShadowFf <= upperByte(ch1ResultFf);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         lightValidFf <= 1'b0;
         nearValidFf  <= 1'b0;
         lightIrqFf   <= 1'b0;
      end else begin
         lightValidFf <= nxt_lightValid;
         nearValidFf  <= nxt_nearValid;
         lightIrqFf   <= nxt_lightIrq;
      end
   end

   // level inputs show in status one cycle late; a host read is far slower than that
   always_ff @(posedge core_clk) begin
      if (reset) begin
         nearSatFf <= 1'b0;
         nearIrqFf <= 1'b0;
      end else begin
         nearSatFf <= nearSaturated;
         nearIrqFf <= nearIrqActive;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdataFf <= `LSC_BYTE_RESET;
      end else begin
         rdataFf <= nxt_rdata;
      end
   end

   // one answer pulse per read, never held over
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rvalidFf <= 1'b0;
      end else begin
         rvalidFf <= regReq.read;
      end
   end

   assign regRdata  = rdataFf;
   assign regRvalid = rvalidFf;

   assign analogControl.ledCurrentSelect = controlFf[`LSC_CTRL_LED_MSB:`LSC_CTRL_LED_LSB];
   assign analogControl.senseDiodeSelect = controlFf[`LSC_CTRL_DIODE_MSB:`LSC_CTRL_DIODE_LSB];
   assign analogControl.nearGainSelect   = controlFf[`LSC_CTRL_NGAIN_MSB:`LSC_CTRL_NGAIN_LSB];
   assign analogControl.lightGainSelect  = controlFf[`LSC_CTRL_LGAIN_MSB:`LSC_CTRL_LGAIN_LSB];

   // reserved diode codes are stored as written; this only flags them
   assign diodeCodeLegal = analogControl.senseDiodeSelect == `LSC_DIODE_CH1;

   // reduce comes straight from its pin, so the current follows it without a register write
   assign ledCurrentTenthsMa = ledCurrent(analogControl.ledCurrentSelect, ledCurrentReduce);
   assign lightIrqFlag       = lightIrqFf;

endmodule

// [tb/lsc_host.sv]
`timescale 1ns/100ps
module lsc_host (
   input  wire logic             core_clk,
   input  wire logic [7:0]       regRdata,
   output lsc_pkg::lsc_reg_req_s regReq
);
   initial regReq = '0;
   // released lines show inverted values so stale data cannot pass
   task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      regReq <= '{w, !w, a, d};
      @(posedge core_clk);
      regReq <= '{1'b0, 1'b0, ~a, ~d};
      @(posedge core_clk);
      q = regRdata;
   endtask
endmodule

// [tb/lsc_regs_props.sv]
`timescale 1ns/100ps
module lsc_regs_props #(
   parameter logic [7:0] PART_CODE = 8'h5a
) (
   input wire logic                         core_clk,
   input wire logic                         reset,
   input wire lsc_pkg::lsc_reg_req_s        regReq,
   input wire logic [7:0]                   regRdata,
   input wire logic                         regRvalid,
   input wire lsc_pkg::lsc_light_result_s   lightResult,
   input wire logic [15:0]                  lightLowThresh,
   input wire logic [15:0]                  lightHighThresh,
   input wire logic                         lightIrqClear,
   input wire logic                         nearSaturated,
   input wire lsc_pkg::lsc_analog_control_s analogControl,
   input wire logic                         lightIrqFlag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire ctlWr = regReq.write && regReq.addr == 8'h0f;
   wire stRd = regReq.read && regReq.addr == 8'h13;
   wire outWin = lightResult.ch0 < lightLowThresh || lightResult.ch0 > lightHighThresh;
   property p_rd_answer; regReq.read |=> regRvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_ctl_write; ctlWr |=> analogControl == $past(regReq.wdata); endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control not written");
   property p_id; regReq.read && regReq.addr == 8'h12 |=> regRdata == PART_CODE; endproperty
   a_id: assert property (p_id) else $error("part code wrong");
   property p_reserved; stRd |=> regRdata[7] == 1'b0 && regRdata[3:2] == 2'h0; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bit set");
   // status lags the level by one cycle, so skip reads right after reset
   property p_sat; stRd && !$past(reset) |=> regRdata[6] == $past(nearSaturated, 2); endproperty
   a_sat: assert property (p_sat) else $error("saturation bit wrong");
   property p_irq_set; lightResult.done && outWin |=> lightIrqFlag; endproperty
   a_irq_set: assert property (p_irq_set) else $error("light irq missed");
   property p_irq_hold; lightIrqFlag && !lightIrqClear |=> lightIrqFlag; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("light irq dropped");
   property p_irq_ch0; lightResult.done && !outWin && !lightIrqFlag |=> !lightIrqFlag; endproperty
   a_irq_ch0: assert property (p_irq_ch0) else $error("light irq without ch0 cause");
   c_status: cover property (stRd);
   c_irq: cover property (lightResult.done && outWin);
   c_ctl: cover property (ctlWr);
endmodule
bind lsc_regs lsc_regs_props #(.PART_CODE(PART_CODE)) u_props (.core_clk(core_clk), .reset(reset),
   .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .lightResult(lightResult),
   .lightLowThresh(lightLowThresh), .lightHighThresh(lightHighThresh), .lightIrqClear(lightIrqClear),
   .nearSaturated(nearSaturated), .analogControl(analogControl), .lightIrqFlag(lightIrqFlag));

// [tb/lsc_regs_tb_top.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nErrors++; \
   $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module lsc_regs_tb_top;
   localparam logic [7:0] PART = 8'h3c;  // arbitrary value
   typedef struct packed {logic w; logic [7:0] a, d, e;} lsc_row_s;
   logic                         core_clk, reset, lvClr, liClr, nDone, nvClr, nSat, nIrq, ledRed;
   logic                         rvalid, legal, irq;
   logic [15:0]                  loTh, hiTh;
   logic [7:0]                   rdata, q;
   logic [10:0]                  ma;
   lsc_pkg::lsc_reg_req_s        regReq;
   lsc_pkg::lsc_light_result_s   res;
   lsc_pkg::lsc_analog_control_s ctl;
   int                           nErrors = 0, cmpCount = 0;
   lsc_row_s                     rows [13] = '{'{1'b1, 8'h0f, 8'ha6, 8'h00},
      '{1'b0, 8'h0f, 8'h00, 8'ha6}, '{1'b1, 8'h0e, 8'h55, 8'h00}, '{1'b0, 8'h0f, 8'h00, 8'ha6},
      '{1'b1, 8'h12, 8'hff, 8'h00}, '{1'b0, 8'h12, 8'h00, PART},
      '{1'b1, 8'h13, 8'hff, 8'h00}, '{1'b0, 8'h13, 8'h00, 8'h43},
      '{1'b0, 8'h14, 8'h00, 8'h34}, '{1'b0, 8'h15, 8'h00, 8'h12},
      '{1'b0, 8'h16, 8'h00, 8'hcd}, '{1'b0, 8'h17, 8'h00, 8'hab},
      '{1'b0, 8'h1a, 8'h00, 8'h00}};
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   lsc_host host (.core_clk(core_clk), .regRdata(rdata), .regReq(regReq));
   lsc_regs #(.PART_CODE(PART)) dut (.core_clk(core_clk), .reset(reset), .regReq(regReq),
      .regRdata(rdata), .regRvalid(rvalid), .lightResult(res), .lightValidClear(lvClr),
      .lightLowThresh(loTh), .lightHighThresh(hiTh), .lightIrqClear(liClr), .nearDone(nDone),
      .nearValidClear(nvClr), .nearSaturated(nSat), .nearIrqActive(nIrq),
      .ledCurrentReduce(ledRed), .analogControl(ctl), .ledCurrentTenthsMa(ma),
      .diodeCodeLegal(legal), .lightIrqFlag(irq));
   task automatic done(input logic [15:0] c0, c1);
      res <= '{1'b1, c0, c1};
      @(posedge core_clk);
      res <= '{1'b0, c0, c1};
      @(posedge core_clk);
   endtask
   task automatic report_and_stop();
      $display("errors %0d compares %0d", nErrors, cmpCount);
      if (nErrors == 0 && cmpCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {reset, lvClr, liClr, nDone, nvClr, nSat, nIrq, ledRed} <= 8'h80;
      res <= '0;
      loTh <= 16'h0100;
      hiTh <= 16'h8000;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      nSat <= 1'b1;
      done(16'h1234, 16'habcd);
      nDone <= 1'b1;
      @(posedge core_clk);
      nDone <= 1'b0;
      foreach (rows[i]) begin
         host.access(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) `CHK(q, rows[i].e)
         `CHK(rvalid, !rows[i].w)
      end
      host.access(1'b0, 8'h14, 8'h00, q);
      done(16'h2200, 16'hffff);
      `CHK(irq, 1'b0)
      host.access(1'b0, 8'h15, 8'h00, q);
      `CHK(q, 8'h12)
      done(16'h0050, 16'h0000);
      `CHK(irq, 1'b1)
      nIrq <= 1'b1;
      @(posedge core_clk);
      host.access(1'b0, 8'h13, 8'h00, q);
      `CHK(q, 8'h73)
      {lvClr, liClr, nvClr, nSat, nIrq} <= 5'h1c;
      @(posedge core_clk);
      {lvClr, liClr, nvClr} <= 3'h0;
      host.access(1'b0, 8'h13, 8'h00, q);
      `CHK(q, 8'h00)
      {lvClr, liClr, nvClr, nDone} <= 4'hf;
      res <= '{1'b1, 16'h0050, 16'h0000};
      @(posedge core_clk);
      {lvClr, liClr, nvClr, nDone} <= 4'h0;
      res <= '{1'b0, 16'h0050, 16'h0000};
      host.access(1'b0, 8'h13, 8'h00, q);
      `CHK(q, 8'h13)
      for (int c = 0; c < 8; c++) begin
         ledRed <= c[2];
         host.access(1'b1, 8'h0f, {4{c[1:0]}}, q);
         `CHK(ctl, {4{c[1:0]}})
         `CHK(legal, c[1:0] == 2'h2)
         `CHK(ma, c[2] ? ((11'h3e8 >> c[1:0]) * 11'h2 + 11'h9) / 11'h12 : 11'h3e8 >> c[1:0])
      end
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      `CHK(ctl, 8'h00)
      host.access(1'b0, 8'h15, 8'h00, q);
      `CHK(q, 8'h00)
      report_and_stop();
   end
   // the sequence needs under a hundred cycles; this margin only catches a hang
   initial begin
      repeat (2000) @(posedge core_clk);
      nErrors++;
      report_and_stop();
   end
endmodule
